// *** src/msp_status.sv ***
// Vendor status flag byte and pin level readback for a four-channel manager.
// Assumes a command decoder supplies page, clear and the events on sys_clk.
//
// Overview of operation
// - Channel sticky flags hold until clear-faults, command-on or control toggle; watchdog holds until clear-faults.
// - Any set alert-raising flag pulls the open-drain alert output low.
// - All-channel flags ignore page; others report the selected page's channel.
// - Only turn-off capable flags feed the channel shutdown request outputs.
// - Bit 7 sets on discharge fault while entering on; sticky, alerting.
// - Bit 6 sets on bus 1 low at turn-on or shutdown; clears on toggle/cycle/clear.
// - Bit 5 sets on bus 0 low at turn-on or shutdown; clears on toggle/cycle/clear.
// - With tracking enabled, the originating channel may also set bus flags.
// - Bit 4 shows live servo target reached; no sticky, no alert.
// - Bit 3 shows live DAC connected and driving; no sticky, no alert.
// - Bit 2 sticky when a servo ended at DAC limit; no alert.
// - Bit 1 live: auxiliary fault output released by voltage or current fault.
// - Bit 0 watchdog fault, shared by all channels, sticky, alerting, no shutdown.
// - Readback is read-only and shows pin levels before any deglitching.
// - Readback bit 15 reads 0 while we pull power-good low.
// - Readback bit 14 reads 0 while we pull alert low.
// - Bits 13:12 show own bus drive, bus 0 upper, 0 means pulling.
// - Bits 9:8 and 7:6 encode select 1 and 0: 11 high, 10 float, 00 low.
// - Bits 5,4,1,0 show on/off inputs 1,0,2,3 levels, high reads 1.
// - Bits 3:2 show bus levels, bus 0 upper, high reads 1.
`timescale 1ns/10ps
module msp_status
  import msp_pkg::*;
#(
  parameter int unsigned N_CH = NUM_CHAN
)(
  input  wire logic                     sys_clk,          // Device clock, 100 MHz
  input  wire logic                     arst_n,           // Async reset, active low
  input  wire logic                     clk_en,           // Freeze all state when low
  input  wire logic [PAGE_W-1:0]        page_sel,         // Selected channel page
  input  wire logic                     clear_faults,     // Clear-faults pulse
  input  wire logic [N_CH-1:0]          chan_on_cmd,      // User commands channel on
  input  wire logic [N_CH-1:0]          on_toggle,        // Control pin toggle or on/off cycle
  input  wire logic [N_CH-1:0]          turn_on_try,      // Channel attempting turn-on
  input  wire logic [N_CH-1:0]          discharge_fault,  // Discharge fault seen
  input  wire logic [N_CH-1:0]          bus1_shutdown,    // Shut down by bus 1
  input  wire logic [N_CH-1:0]          bus0_shutdown,    // Shut down by bus 0
  input  wire logic [N_CH-1:0]          track_en,         // Channel tracking enable
  input  wire logic [N_CH-1:0]          bus1_origin,      // Channel drove bus 1 fault
  input  wire logic [N_CH-1:0]          bus0_origin,      // Channel drove bus 0 fault
  input  wire logic [N_CH-1:0]          servo_done,       // Servo target reached, live
  input  wire logic [N_CH-1:0]          dac_connected,    // DAC driving output, live
  input  wire logic [N_CH-1:0]          dac_sat_event,    // Servo ended at DAC limit
  input  wire logic [N_CH-1:0]          aux_fault_off,    // Aux fault output released
  input  wire logic                     watchdog_event,   // Watchdog fault
  input  wire logic [N_CH-1:0]          off_cfg_en,       // Shutdown enable per channel
  input  wire logic                     shared_fault_bus0_n, // Raw bus 0 level
  input  wire logic                     shared_fault_bus1_n, // Raw bus 1 level
  input  wire logic                     bus0_pull,        // We pull bus 0 low
  input  wire logic                     bus1_pull,        // We pull bus 1 low
  input  wire logic                     pgood_pull,       // We pull power-good low
  input  wire logic [1:0]               addr_select_in0,  // Select 0 {driven, level}
  input  wire logic [1:0]               addr_select_in1,  // Select 1 {driven, level}
  input  wire logic                     on_off_input0,    // Raw on/off 0
  input  wire logic                     on_off_input1,    // Raw on/off 1
  input  wire logic                     on_off_input2,    // Raw on/off 2
  input  wire logic                     on_off_input3,    // Raw on/off 3
  output logic [7:0]                    vendor_status_flags, // Paged flag byte
  output logic [15:0]                   pin_level_readback,  // Pad readback word
  output logic                          alert_out,        // Alert pin output value
  output logic                          alert_oe_n,       // Alert enable, low drives
  output logic [N_CH-1:0]               shutdown_req      // Channel off request
);
  // Select pin decode: driven high, driven low, or floating
  function automatic logic [1:0] sel_code(input logic [1:0] pin);
    if (!pin[1]) begin
      sel_code = MSP_SEL_FLOAT;
    end else if (pin[0]) begin
      sel_code = MSP_SEL_HIGH;
    end else begin
      sel_code = MSP_SEL_LOW;
    end
  endfunction : sel_code

  logic [N_CH-1:0] st_dis;
  logic [N_CH-1:0] st_b1;
  logic [N_CH-1:0] st_b0;
  logic [N_CH-1:0] st_sat;
  logic [N_CH-1:0] ev_b1;
  logic [N_CH-1:0] ev_b0;
  logic [N_CH-1:0] ev_dis;
  logic [N_CH-1:0] chan_alert;

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      // Turn-on while bus low, shutdown by bus, or origin under tracking
      assign ev_b1[g]  = (turn_on_try[g] && !shared_fault_bus1_n) || bus1_shutdown[g]
                         || (track_en[g] && bus1_origin[g]);
      assign ev_b0[g]  = (turn_on_try[g] && !shared_fault_bus0_n) || bus0_shutdown[g]
                         || (track_en[g] && bus0_origin[g]);
      assign ev_dis[g] = discharge_fault[g] && turn_on_try[g];

      // All four flags clear on control toggle as well as on command-on
      msp_chan_flags u_flags (
        .sys_clk        (sys_clk),
        .arst_n         (arst_n),
        .clk_en         (clk_en),
        .clr_all        (clear_faults),
        .chan_on_cmd    (chan_on_cmd[g] || on_toggle[g]),
        .ev_discharge   (ev_dis[g]),
        .ev_bus1        (ev_b1[g]),
        .ev_bus0        (ev_b0[g]),
        .ev_dac_sat     (dac_sat_event[g]),
        .flag_discharge (st_dis[g]),
        .flag_bus1      (st_b1[g]),
        .flag_bus0      (st_b0[g]),
        .flag_dac_sat   (st_sat[g])
      );
      assign chan_alert[g] = st_dis[g] | st_b1[g] | st_b0[g];
      // Watchdog deliberately excluded from shutdown
      assign shutdown_req[g] = off_cfg_en[g] & (st_dis[g] | st_b1[g] | st_b0[g]);
    end
  endgenerate

  // Watchdog flag, shared by all channels
  logic wdog_ff;
  logic nxt_wdog;
  always_comb begin
    nxt_wdog = wdog_ff;
    if (clear_faults) begin
      nxt_wdog = 1'b0;
    end
    nxt_wdog = nxt_wdog | watchdog_event;
  end

  // Registered outputs
  logic [7:0]  flags_ff;
  logic [7:0]  nxt_flags;
  logic [15:0] pads_ff;
  logic [15:0] nxt_pads;
  logic        alert_ff;
  logic        nxt_alert;

  always_comb begin
    nxt_flags = FLAGS_RST;
    nxt_flags[SF_DISCHARGE]  = st_dis[page_sel];
    nxt_flags[SF_BUS1_IN]    = st_b1[page_sel];
    nxt_flags[SF_BUS0_IN]    = st_b0[page_sel];
    nxt_flags[SF_SERVO_DONE] = servo_done[page_sel];
    nxt_flags[SF_DAC_CONN]   = dac_connected[page_sel];
    nxt_flags[SF_DAC_SAT]    = st_sat[page_sel];
    nxt_flags[SF_AUX_OFF]    = aux_fault_off[page_sel];
    nxt_flags[SF_WATCHDOG]   = wdog_ff;
  end

  always_comb begin
    // Alert watches every channel, not just the paged one
    nxt_alert = (|chan_alert) | wdog_ff;
  end

  always_comb begin
    // Raw pins, no deglitch: a glitch may show in a single read
    nxt_pads = READBACK_RST;
    nxt_pads[PR_PGOOD_DRV] = ~pgood_pull;
    nxt_pads[PR_ALERT_DRV] = ~alert_ff;
    nxt_pads[PR_BUS0_DRV]  = ~bus0_pull;
    nxt_pads[PR_BUS1_DRV]  = ~bus1_pull;
    nxt_pads[PR_ADDR_SELECT_IN1_LSB +: 2] = sel_code(addr_select_in1);
    nxt_pads[PR_ADDR_SELECT_IN0_LSB +: 2] = sel_code(addr_select_in0);
    nxt_pads[PR_ON1] = on_off_input1;
    nxt_pads[PR_ON0] = on_off_input0;
    nxt_pads[PR_ON2] = on_off_input2;
    nxt_pads[PR_ON3] = on_off_input3;
    nxt_pads[PR_BUS0_LVL] = shared_fault_bus0_n;
    nxt_pads[PR_BUS1_LVL] = shared_fault_bus1_n;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_ff  <= 1'b0;
      flags_ff <= FLAGS_RST;
      pads_ff  <= READBACK_RST;
      alert_ff <= 1'b0;
    end else if (clk_en) begin
      wdog_ff  <= nxt_wdog;
      flags_ff <= nxt_flags;
      pads_ff  <= nxt_pads;
      alert_ff <= nxt_alert;
    end
  end

  assign vendor_status_flags = flags_ff;
  assign pin_level_readback  = pads_ff;
  // Open-drain: output value always low, enable low while pulling
  assign alert_out  = 1'b0;
  assign alert_oe_n = ~alert_ff;
endmodule : msp_status

// *** pkg/msp_pkg.sv ***
// Constants for the vendor status flags and pin level readback block.
// Assumes a four-channel manager with paged commands and one device clock.
package msp_pkg;
  localparam int unsigned NUM_CHAN        = 4;
  localparam int unsigned PAGE_W          = 2;
  // Status flag bit positions
  localparam int unsigned SF_DISCHARGE    = 7;
  localparam int unsigned SF_BUS1_IN      = 6;
  localparam int unsigned SF_BUS0_IN      = 5;
  localparam int unsigned SF_SERVO_DONE   = 4;
  localparam int unsigned SF_DAC_CONN     = 3;
  localparam int unsigned SF_DAC_SAT      = 2;
  localparam int unsigned SF_AUX_OFF      = 1;
  localparam int unsigned SF_WATCHDOG     = 0;
  // Readback bit positions
  localparam int unsigned PR_PGOOD_DRV    = 15;
  localparam int unsigned PR_ALERT_DRV    = 14;
  localparam int unsigned PR_BUS0_DRV     = 13;
  localparam int unsigned PR_BUS1_DRV     = 12;
  localparam int unsigned PR_ADDR_SELECT_IN1_LSB    = 8;
  localparam int unsigned PR_ADDR_SELECT_IN0_LSB    = 6;
  localparam int unsigned PR_ON1          = 5;
  localparam int unsigned PR_ON0          = 4;
  localparam int unsigned PR_BUS0_LVL     = 3;
  localparam int unsigned PR_BUS1_LVL     = 2;
  localparam int unsigned PR_ON2          = 1;
  localparam int unsigned PR_ON3          = 0;
  localparam logic [7:0]  FLAGS_RST       = 8'h00;
  localparam logic [15:0] READBACK_RST    = 16'h0000;
  localparam logic [7:0]  STICKY_MASK     = 8'hE5;
  localparam logic [7:0]  ALERT_MASK      = 8'hE1;
  localparam logic [7:0]  TURNOFF_MASK    = 8'hE0;
  // Three-level select codes
  typedef enum logic [1:0] {
    MSP_SEL_LOW   = 2'b00,
    MSP_SEL_RSVD  = 2'b01,
    MSP_SEL_FLOAT = 2'b10,
    MSP_SEL_HIGH  = 2'b11
  } msp_sel_e;
endpackage : msp_pkg

// *** src/msp_chan_flags.sv ***
// One channel's sticky status flags.
// Assumes event inputs are single-cycle or level, synchronous to sys_clk.
`timescale 1ns/10ps
module msp_chan_flags
  import msp_pkg::*;
(
  input  wire logic sys_clk,       // Device clock
  input  wire logic arst_n,        // Async reset
  input  wire logic clk_en,        // Freeze when low
  input  wire logic clr_all,       // Clear-faults command
  input  wire logic chan_on_cmd,   // Channel commanded on
  input  wire logic ev_discharge,  // Discharge fault event
  input  wire logic ev_bus1,       // Bus 1 event
  input  wire logic ev_bus0,       // Bus 0 event
  input  wire logic ev_dac_sat,    // DAC saturated event
  output logic      flag_discharge,// Sticky discharge
  output logic      flag_bus1,     // Sticky bus 1
  output logic      flag_bus0,     // Sticky bus 0
  output logic      flag_dac_sat   // Sticky saturation
);
  logic [3:0] flags_ff;
  logic [3:0] nxt_flags;
  logic [3:0] ev;

  assign ev = {ev_discharge, ev_bus1, ev_bus0, ev_dac_sat};

  always_comb begin
    nxt_flags = flags_ff;
    if (clr_all || chan_on_cmd) begin
      nxt_flags = 4'h0;
    end
    nxt_flags = nxt_flags | ev;    // Set wins over clear
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_ff <= 4'h0;
    end else if (clk_en) begin
      flags_ff <= nxt_flags;
    end
  end

  assign flag_discharge = flags_ff[3];
  assign flag_bus1      = flags_ff[2];
  assign flag_bus0      = flags_ff[1];
  assign flag_dac_sat   = flags_ff[0];
endmodule : msp_chan_flags

// *** tb/msp_status_assertions.sv ***
// Port checker for msp_status.
// Bound to msp_status; sees its ports only.
`timescale 1ns/10ps
module msp_status_assertions
  import msp_pkg::*;
#(
  parameter int unsigned N_CH = NUM_CHAN
)(
  input wire logic              sys_clk,             // Clock
  input wire logic              arst_n,              // Reset
  input wire logic              clk_en,              // Advance
  input wire logic [PAGE_W-1:0] page_sel,            // Page
  input wire logic              clear_faults,        // Clear
  input wire logic              watchdog_event,      // Watchdog
  input wire logic [N_CH-1:0]   servo_done,          // Live servo
  input wire logic [N_CH-1:0]   off_cfg_en,          // Off enable
  input wire logic              shared_fault_bus0_n, // Bus 0
  input wire logic              shared_fault_bus1_n, // Bus 1
  input wire logic              bus0_pull,           // Own pull 0
  input wire logic              bus1_pull,           // Own pull 1
  input wire logic              pgood_pull,          // Own pull pgood
  input wire logic [1:0]        addr_select_in1,     // Select 1
  input wire logic [7:0]        vendor_status_flags, // Flags
  input wire logic [15:0]       pin_level_readback,  // Readback
  input wire logic              alert_out,           // Alert value
  input wire logic              alert_oe_n,          // Alert enable
  input wire logic [N_CH-1:0]   shutdown_req         // Off request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_wd_set; clk_en && watchdog_event |-> ##[1:2] vendor_status_flags[SF_WATCHDOG]; endproperty
  a_wd_set: assert property (p_wd_set) else $error("watchdog flag missing");
  property p_sticky;
    vendor_status_flags[0] && !clear_faults && !$past(clear_faults) |=> vendor_status_flags[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag lost");
  property p_alert; (vendor_status_flags & ALERT_MASK) != 8'h00 |-> !alert_oe_n && !alert_out; endproperty
  a_alert: assert property (p_alert) else $error("alert not driven");
  property p_live; clk_en |=> vendor_status_flags[SF_SERVO_DONE] == $past(servo_done[page_sel]); endproperty
  a_live: assert property (p_live) else $error("servo bit wrong");
  // Stronger than an all-off antecedent: every request needs its enable
  property p_off; (shutdown_req & ~off_cfg_en) == '0; endproperty
  a_off: assert property (p_off) else $error("unexpected shutdown");
  property p_drv; clk_en |=> pin_level_readback[15:14] == {!$past(pgood_pull), $past(alert_oe_n)}; endproperty
  a_drv: assert property (p_drv) else $error("drive bits wrong");
  property p_bus; clk_en |=> pin_level_readback[13:10] == {!$past(bus0_pull), !$past(bus1_pull), 2'h0}
    && pin_level_readback[3:2] == {$past(shared_fault_bus0_n), $past(shared_fault_bus1_n)}; endproperty
  a_bus: assert property (p_bus) else $error("bus bits wrong");
  property p_sel;
    clk_en |=> pin_level_readback[9:8] == ($past(addr_select_in1[1]) ? {2{$past(addr_select_in1[0])}} : 2'h2);
  endproperty
  a_sel: assert property (p_sel) else $error("select code wrong");
endmodule : msp_status_assertions
bind msp_status msp_status_assertions #(.N_CH(N_CH)) u_msp_status_assertions (.*);

// *** tb/msp_host_model.sv ***
// Host side: latches both read-only words on a read strobe.
// Assumes rd changes away from the rising edge.
`timescale 1ns/10ps
module msp_host_model (
  input  wire logic        sys_clk,  // Clock
  input  wire logic        rd,       // Read strobe
  input  wire logic [7:0]  flags,    // Status byte
  input  wire logic [15:0] pads,     // Readback word
  output logic      [7:0]  rd_flags, // Byte seen
  output logic      [15:0] rd_pads   // Word seen
);
  always_ff @(posedge sys_clk) begin
    if (rd) begin
      rd_flags <= flags;
      rd_pads  <= pads;
    end
  end
endmodule : msp_host_model

// *** tb/msp_status_tb.sv ***
// Scenario bench for msp_status, reading through the host model.
// Assumes inputs move on the falling edge only.
`timescale 1ns/10ps
module msp_status_tb;
  import msp_pkg::*;
  logic        sys_clk, arst_n, clk_en, clear_faults, watchdog_event, rd, alert_out, alert_oe_n, pgood_pull;
  logic        shared_fault_bus0_n, shared_fault_bus1_n, bus0_pull, bus1_pull;
  logic        on_off_input0, on_off_input1, on_off_input2, on_off_input3;
  logic [1:0]  page_sel, addr_select_in0, addr_select_in1;
  logic [3:0]  chan_on_cmd, on_toggle, turn_on_try, discharge_fault, bus1_shutdown, bus0_shutdown, track_en;
  logic [3:0]  bus1_origin, bus0_origin, servo_done, dac_connected, dac_sat_event, aux_fault_off, off_cfg_en;
  logic [3:0]  shutdown_req;
  logic [7:0]  vendor_status_flags, rd_flags;
  logic [15:0] pin_level_readback, rd_pads, e;
  int          failures = 0, total_checks = 0;
  msp_status u_msp_status (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .page_sel(page_sel), .clear_faults(clear_faults),
    .chan_on_cmd(chan_on_cmd), .on_toggle(on_toggle), .turn_on_try(turn_on_try),
    .discharge_fault(discharge_fault), .bus1_shutdown(bus1_shutdown), .bus0_shutdown(bus0_shutdown),
    .track_en(track_en), .bus1_origin(bus1_origin), .bus0_origin(bus0_origin), .servo_done(servo_done),
    .dac_connected(dac_connected), .dac_sat_event(dac_sat_event), .aux_fault_off(aux_fault_off),
    .watchdog_event(watchdog_event), .off_cfg_en(off_cfg_en),
    .shared_fault_bus0_n(shared_fault_bus0_n), .shared_fault_bus1_n(shared_fault_bus1_n),
    .bus0_pull(bus0_pull), .bus1_pull(bus1_pull), .pgood_pull(pgood_pull),
    .addr_select_in0(addr_select_in0), .addr_select_in1(addr_select_in1),
    .on_off_input0(on_off_input0), .on_off_input1(on_off_input1),
    .on_off_input2(on_off_input2), .on_off_input3(on_off_input3),
    .vendor_status_flags(vendor_status_flags), .pin_level_readback(pin_level_readback),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n), .shutdown_req(shutdown_req));
  msp_host_model u_msp_host_model (.sys_clk(sys_clk), .rd(rd), .flags(vendor_status_flags),
    .pads(pin_level_readback), .rd_flags(rd_flags), .rd_pads(rd_pads));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic ev_off;
    {clear_faults, watchdog_event, chan_on_cmd, on_toggle, discharge_fault, turn_on_try} = '0;
    {bus1_shutdown, bus0_shutdown, bus1_origin, bus0_origin, dac_sat_event} = '0;
  endtask : ev_off
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Page change needs a cycle before the byte follows it
  task automatic rd_page(input logic [1:0] p);
    page_sel = p;
    step(2);
    rd = 1'h1;
    step(1);
    rd = 1'h0;
  endtask : rd_page
  function automatic logic [1:0] sel_code(input logic [1:0] v);
    return v[1] ? {2{v[0]}} : 2'h2;
  endfunction : sel_code
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic t_wd;
    off_cfg_en = 4'hF;
    watchdog_event = 1'h1;
    step(1);
    ev_off;
    for (int p = 0; p < 4; p++) begin
      rd_page(2'(p));
      chk(rd_flags, 16'h01);
    end
    chk({alert_out, alert_oe_n, pin_level_readback[14], shutdown_req}, 16'h0);
    clear_faults = 1'h1;
    step(1);
    ev_off;
    rd_page(2'h0);
    chk({rd_flags, alert_oe_n}, 16'h1);
  endtask : t_wd
  task automatic t_chan;
    off_cfg_en = 4'h4;
    discharge_fault = 4'h4;
    bus1_shutdown = 4'h2;
    bus0_shutdown = 4'h2;
    {track_en, bus1_origin, bus0_origin, dac_sat_event} = 16'h8881;
    step(1);
    ev_off;
    rd_page(2'h2);
    chk({rd_flags, shutdown_req}, 16'h0);
    turn_on_try = 4'h4;
    discharge_fault = 4'h4;
    step(1);
    ev_off;
    rd_page(2'h2);
    chk({rd_flags, shutdown_req, alert_oe_n}, 16'h1008);
    chan_on_cmd = 4'h4;
    on_toggle = 4'h2;
    step(1);
    ev_off;
    for (int p = 0; p < 4; p++) begin
      rd_page(2'(p));
      chk(rd_flags, (p == 3) ? 16'h60 : (p == 0) ? 16'h04 : 16'h00);
    end
    // Turn-on attempts while one bus is held low
    {shared_fault_bus1_n, turn_on_try} = 5'h02;
    step(1);
    {shared_fault_bus1_n, shared_fault_bus0_n, turn_on_try} = 6'h21;
    step(1);
    ev_off;
    shared_fault_bus0_n = 1'h1;
    rd_page(2'h1);
    chk(rd_flags, 16'h40);
    rd_page(2'h0);
    chk(rd_flags, 16'h24);
    clear_faults = 1'h1;
    step(1);
    ev_off;
    rd_page(2'h3);
    chk({rd_flags, alert_oe_n}, 16'h1);
  endtask : t_chan
  task automatic t_live;
    {servo_done, dac_connected, aux_fault_off} = 12'h111;
    rd_page(2'h0);
    chk({rd_flags, alert_oe_n}, 16'h35);
    servo_done = 4'h0;
    rd_page(2'h0);
    chk(rd_flags, 16'h0A);
    // Frozen clock enable must hold the byte
    clk_en = 1'h0;
    servo_done = 4'h1;
    step(2);
    chk(vendor_status_flags, 16'h0A);
    clk_en = 1'h1;
  endtask : t_live
  task automatic t_pads;
    for (int i = 0; i < 4; i++) begin
      {pgood_pull, bus0_pull, bus1_pull} = {i[0], i[1], !i[1]};
      {shared_fault_bus0_n, shared_fault_bus1_n} = {!i[1], i[1] & i[0]};
      {addr_select_in1, addr_select_in0} = {i[1], i[0], i[0], !i[1]};
      {on_off_input0, on_off_input1, on_off_input2, on_off_input3} = {i[0], i[1], !i[0], i[1] ^ i[0]};
      e = {!i[0], 1'h1, !i[1], i[1], 2'h0, sel_code({i[1], i[0]}), sel_code({i[0], !i[1]}),
           i[1], i[0], !i[1], i[1] & i[0], !i[0], i[1] ^ i[0]};
      rd_page(2'h0);
      chk(rd_pads, e);
    end
  endtask : t_pads
  initial begin
    {arst_n, rd, page_sel, track_en, servo_done, dac_connected, aux_fault_off, off_cfg_en} = '0;
    {pgood_pull, bus0_pull, bus1_pull, addr_select_in0, addr_select_in1} = '0;
    {on_off_input0, on_off_input1, on_off_input2, on_off_input3} = '0;
    {clk_en, shared_fault_bus0_n, shared_fault_bus1_n} = 3'h7;
    ev_off;
    step(4);
    arst_n = 1'h1;
    step(1);
    t_wd;
    t_chan;
    t_live;
    t_pads;
    watchdog_event = 1'h1;
    step(1);
    ev_off;
    step(3);
    chk({vendor_status_flags[SF_WATCHDOG], alert_oe_n}, 16'h2);
    arst_n = 1'h0;
    step(1);
    chk({vendor_status_flags, alert_oe_n}, {FLAGS_RST, 1'h1});
    chk(pin_level_readback, READBACK_RST);
    results;
  end
endmodule : msp_status_tb
